// ===== rtl/loe_ladder_output_executor.sv
// Output instruction executor: coils, timers, counters, set/reset, edge pulses
`timescale 1ns/100ps
`include "loe_regs.svh"
module loe_ladder_output_executor #(
	parameter int NRELAY = 64,
	parameter int NTIMER = 16,
	parameter int NCOUNT = 16,
	parameter int NDATA = 16,
	parameter int NPULSE = 16,
	parameter int BASE100_CYC = `LOE_BASE100_CYC,
	parameter int BASE10_CYC = `LOE_BASE10_CYC
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic run,
	// Instruction stream from the sequencer, one instruction a cycle
	input wire logic instrValid,
	input wire loe_pkg::loe_op_e instrOp,
	input wire loe_pkg::loe_tgt_e instrTarget,
	input wire logic [7:0] instrIndex,
	input wire logic [15:0] instrSetting,
	input wire logic [7:0] instrPulseSlot,
	input wire logic opResult,
	// Step length and device image
	output logic [2:0] instrSteps,
	output logic [NRELAY-1:0] relayState,
	output logic [NTIMER-1:0] timerCoil,
	output logic [NTIMER-1:0] timerContact,
	output logic [NCOUNT-1:0] counterCoil,
	output logic [NCOUNT-1:0] counterContact,
	output logic [NDATA*16-1:0] dataClearMask,
	output logic [NTIMER*16-1:0] timerValue,
	output logic [NCOUNT*16-1:0] counterValue,
	// Static per-timer type: 100 ms, 10 ms or retentive 100 ms
	input wire logic [NTIMER*2-1:0] timerMode
);
	// Scan model: the sequencer walks the program one instruction a cycle while run is high.
	// Each coil, timer, counter, set, reset and pulse instruction updates state on the edge
	// that takes it, so its result is visible to the next instruction. Nothing here knows where
	// a scan ends; program order alone defines it, and the pulse slots carry the last command.
	// While run is low no instruction is taken, which freezes the image and the pulse memory.

	// ----------------------------------------
	// Time base enables
	// ----------------------------------------
	// Both bases free-run from reset; a timer only banks a tick while its coil is on
	logic [31:0] div100;
	logic [31:0] div10;
	wire tick100 = (div100 == 32'(BASE100_CYC - 1));
	wire tick10 = (div10 == 32'(BASE10_CYC - 1));
	wire [31:0] next_div100 = tick100 ? 32'h0 : div100 + 32'h1;
	wire [31:0] next_div10 = tick10 ? 32'h0 : div10 + 32'h1;
	logic [NTIMER-1:0] pend100;
	logic [NTIMER-1:0] pend10;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			div100 <= 32'h0;
		end else begin
			div100 <= next_div100;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			div10 <= 32'h0;
		end else begin
			div10 <= next_div10;
		end
	end

	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	// Device number compare, shared by every per-device slice
	function automatic logic indexHit(input logic [7:0] idx, input int unsigned n);
		return idx == 8'(n);
	endfunction

	// Word devices take the long reset form
	function automatic logic isWordTarget(input loe_pkg::loe_tgt_e t);
		return t == loe_pkg::LOE_TGT_TIMER || t == loe_pkg::LOE_TGT_COUNTER || t == loe_pkg::LOE_TGT_DATA;
	endfunction

	// ----------------------------------------
	// Instruction decode
	// ----------------------------------------
	// Instructions are refused while stopped, so no device image bit moves in STOP; the time bases and tick banks still run
	wire take = instrValid && run;
	wire isCoil = take && instrOp == loe_pkg::LOE_OP_COIL;
	wire isTimer = take && instrOp == loe_pkg::LOE_OP_TIMER;
	wire isCount = take && instrOp == loe_pkg::LOE_OP_COUNTER;
	wire isSet = take && instrOp == loe_pkg::LOE_OP_SET;
	wire isReset = take && instrOp == loe_pkg::LOE_OP_RESET;
	wire isRise = take && instrOp == loe_pkg::LOE_OP_RISE;
	wire isFall = take && instrOp == loe_pkg::LOE_OP_FALL;
	wire tgtSpecial = instrTarget == loe_pkg::LOE_TGT_SPECIAL;
	wire tgtWord = isWordTarget(instrTarget);
	wire tgtRelay = instrTarget == loe_pkg::LOE_TGT_RELAY || tgtSpecial;
	wire longStep = ((instrOp == loe_pkg::LOE_OP_COIL || instrOp == loe_pkg::LOE_OP_SET) && tgtSpecial)
		|| (instrOp == loe_pkg::LOE_OP_RESET && (tgtSpecial || tgtWord));

	// Step length reported so the sequencer advances its step pointer
	assign instrSteps = longStep ? `LOE_STEPS_LONG : `LOE_STEPS_NORMAL;

	// ----------------------------------------
	// Relays: coil, set, reset, edge pulses
	// ----------------------------------------
	localparam int SLOTW = $clog2(NPULSE);
	logic [NPULSE-1:0] prevCmd;
	wire [SLOTW-1:0] slot = instrPulseSlot[SLOTW-1:0];
	wire prevSlot = prevCmd[slot];
	wire riseHit = opResult && !prevSlot;
	wire fallHit = !opResult && prevSlot;

	genvar g;
	generate
		for (g = 0; g < NRELAY; g++) begin : gRelay
			wire hit = tgtRelay && indexHit(instrIndex, g);
			wire doCoil = hit && isCoil;
			wire doSet = hit && isSet && opResult;
			wire doClear = hit && isReset && opResult;
			wire doRise = hit && isRise;
			wire doFall = hit && isFall;
			wire change = doCoil || doSet || doClear || doRise || doFall;
			wire next_relay = doCoil ? opResult
				: doSet ? 1'b1
				: doClear ? 1'b0
				: doRise ? riseHit
				: fallHit;
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					relayState[g] <= 1'b0;
				end else if (change) begin
					relayState[g] <= next_relay;
				end
			end
		end
	endgenerate

	// Pulse memory moves only on a taken instruction, so a STOP/RUN cycle leaves no false edge
	generate
		for (g = 0; g < NPULSE; g++) begin : gPulse
			wire own = (isRise || isFall) && slot == SLOTW'(g);
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					prevCmd[g] <= 1'b0;
				end else if (own) begin
					prevCmd[g] <= opResult;
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Timers
	// ----------------------------------------
	generate
		for (g = 0; g < NTIMER; g++) begin : gTimer
			logic [15:0] pv;
			logic [15:0] setv;
			logic [15:0] next_pv;
			logic next_coil;
			logic next_contact;
			wire hitT = indexHit(instrIndex, g) && instrTarget == loe_pkg::LOE_TGT_TIMER;
			wire runT = hitT && isTimer;
			wire clearT = hitT && isReset && opResult;

			wire [1:0] mode = timerMode[2*g +: 2];
			wire retentive = mode == 2'(loe_pkg::LOE_TM_RET);
			wire fast = mode == 2'(loe_pkg::LOE_TM_10);
			wire base = fast ? pend10[g] : pend100[g];

			wire [15:0] next_setv = runT ? instrSetting : setv;
			wire infinite = next_setv == 16'h0;
			// An endless timer stops at the top of the range instead of wrapping
			wire atLimit = infinite ? pv == 16'hffff : pv >= next_setv;
			wire advance = opResult && base && !atLimit;
			wire [15:0] pvStep = advance ? pv + 16'h1 : pv;
			// Contact follows the value just reached, so time-out shows in this scan
			wire reached = !infinite && pvStep >= next_setv;
			wire consume = runT && (base || !opResult);
			assign timerValue[16*g +: 16] = pv;

			always_comb begin
				next_pv = pv;
				next_coil = timerCoil[g];
				next_contact = timerContact[g];
				if (clearT) begin
					next_pv = 16'h0;
					next_coil = 1'b0;
					next_contact = 1'b0;
				end else if (runT) begin
					next_coil = opResult;
					if (opResult) begin
						next_pv = pvStep;
						next_contact = reached;
					end else if (!retentive) begin
						next_pv = 16'h0;
						next_contact = 1'b0;
					end
					// A retentive timer keeps value and contact with its input off
				end
			end

			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					pv <= 16'h0;
				end else begin
					pv <= next_pv;
				end
			end

			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					setv <= 16'h0;
				end else begin
					setv <= next_setv;
				end
			end

			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					timerCoil[g] <= 1'b0;
				end else begin
					timerCoil[g] <= next_coil;
				end
			end

			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					timerContact[g] <= 1'b0;
				end else begin
					timerContact[g] <= next_contact;
				end
			end

			// A tick banked between executions is spent on the next one; a fresh tick in the
			// cycle that spends the old one wins, so no base period is lost
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					pend100[g] <= 1'b0;
					pend10[g] <= 1'b0;
				end else begin
					pend100[g] <= tick100 ? timerCoil[g] : pend100[g] && !consume;
					pend10[g] <= tick10 ? timerCoil[g] : pend10[g] && !consume;
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Counters
	// ----------------------------------------
	generate
		for (g = 0; g < NCOUNT; g++) begin : gCount
			logic [15:0] pv;
			logic [15:0] next_pv;
			logic next_coil;
			logic next_contact;
			wire hitC = indexHit(instrIndex, g) && instrTarget == loe_pkg::LOE_TGT_COUNTER;
			wire runC = hitC && isCount;
			wire clearC = hitC && isReset && opResult;

			wire [15:0] limit = (instrSetting == 16'h0) ? 16'h1 : instrSetting;
			// The coil holds last scan's input, which makes the count edge-driven
			wire rising = opResult && !counterCoil[g];
			wire [15:0] pvInc = pv + 16'h1;
			assign counterValue[16*g +: 16] = pv;

			always_comb begin
				next_pv = pv;
				next_coil = counterCoil[g];
				next_contact = counterContact[g];
				if (clearC) begin
					next_pv = 16'h0;
					next_coil = 1'b0;
					next_contact = 1'b0;
				end else if (runC) begin
					next_coil = opResult;
					// A finished counter ignores its input until reset
					if (rising && !counterContact[g]) begin
						next_pv = pvInc;
						next_contact = pvInc >= limit;
					end
				end
			end

			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					pv <= 16'h0;
				end else begin
					pv <= next_pv;
				end
			end

			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					counterCoil[g] <= 1'b0;
				end else begin
					counterCoil[g] <= next_coil;
				end
			end

			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					counterContact[g] <= 1'b0;
				end else begin
					counterContact[g] <= next_contact;
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Data register clear strobes
	// ----------------------------------------
	// One-cycle strobe; the data memory outside clears every word it marks
	generate
		for (g = 0; g < NDATA; g++) begin : gData
			wire clr = isReset && opResult && instrTarget == loe_pkg::LOE_TGT_DATA && indexHit(instrIndex, g);
			wire [15:0] next_mask = {16{clr}};
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					dataClearMask[16*g +: 16] <= 16'h0;
				end else begin
					dataClearMask[16*g +: 16] <= next_mask;
				end
			end
		end
	endgenerate
endmodule // loe_ladder_output_executor

// ===== include/loe_regs.svh
// Constants of the ladder output executor
`ifndef LOE_REGS_SVH
`define LOE_REGS_SVH
`define LOE_CLK_HZ 40000000
`define LOE_BASE100_MS 100
`define LOE_BASE10_MS 10
`define LOE_BASE100_CYC ((`LOE_CLK_HZ / 1000) * `LOE_BASE100_MS)
`define LOE_BASE10_CYC ((`LOE_CLK_HZ / 1000) * `LOE_BASE10_MS)
`define LOE_STEPS_NORMAL 3'h1
`define LOE_STEPS_LONG 3'h3
`endif

// ===== include/loe_pkg.sv
// Types of the ladder output executor
package loe_pkg;
	typedef enum logic [3:0] {
		LOE_OP_NONE = 4'h0,
		LOE_OP_COIL = 4'h1,
		LOE_OP_TIMER = 4'h2,
		LOE_OP_COUNTER = 4'h3,
		LOE_OP_SET = 4'h4,
		LOE_OP_RESET = 4'h5,
		LOE_OP_RISE = 4'h6,
		LOE_OP_FALL = 4'h7
	} loe_op_e;
	typedef enum logic [2:0] {
		LOE_TGT_RELAY = 3'h0,
		LOE_TGT_SPECIAL = 3'h1,
		LOE_TGT_TIMER = 3'h2,
		LOE_TGT_COUNTER = 3'h3,
		LOE_TGT_DATA = 3'h4
	} loe_tgt_e;
	typedef enum logic [1:0] {
		LOE_TM_100 = 2'h0,
		LOE_TM_10 = 2'h1,
		LOE_TM_RET = 2'h2
	} loe_tmode_e;
endpackage

// ===== test/loe_executor_asserts.sv
// Checker of the ladder output executor ports
`timescale 1ns/100ps
module loe_executor_asserts #(
	parameter int NRELAY = 64,
	parameter int NTIMER = 16,
	parameter int NCOUNT = 16,
	parameter int NDATA = 16
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic run,
	input wire logic instrValid,
	input wire loe_pkg::loe_op_e instrOp,
	input wire loe_pkg::loe_tgt_e instrTarget,
	input wire logic [7:0] instrIndex,
	input wire logic opResult,
	input wire logic [2:0] instrSteps,
	input wire logic [NRELAY-1:0] relayState,
	input wire logic [NTIMER-1:0] timerContact,
	input wire logic [NDATA*16-1:0] dataClearMask,
	input wire logic [NTIMER*16-1:0] timerValue,
	input wire logic [NCOUNT*16-1:0] counterValue,
	input wire logic [NTIMER*2-1:0] timerMode
);
	// ----------
	// Properties
	// ----------
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	wire go = instrValid && run;
	wire rly = go && instrTarget == loe_pkg::LOE_TGT_RELAY;
	wire rstOn = go && instrOp == loe_pkg::LOE_OP_RESET && opResult;
	property p_coil; rly && instrOp == loe_pkg::LOE_OP_COIL |=> relayState[$past(instrIndex)] == $past(opResult); endproperty
	property p_set; rly && instrOp == loe_pkg::LOE_OP_SET && opResult |=> relayState[$past(instrIndex)]; endproperty
	property p_rst; rly && rstOn |=> !relayState[$past(instrIndex)]; endproperty
	property p_stop; !run |=> $stable(relayState); endproperty
	property p_data; rstOn && instrTarget == loe_pkg::LOE_TGT_DATA |=> dataClearMask[$past(instrIndex)*16 +: 16] == 16'hffff;
	endproperty
	property p_stepW; instrValid && instrOp == loe_pkg::LOE_OP_RESET && instrTarget == loe_pkg::LOE_TGT_DATA
		|-> instrSteps == 3'h3; endproperty
	property p_stepR; instrValid && instrTarget == loe_pkg::LOE_TGT_RELAY |-> instrSteps == 3'h1; endproperty
	property p_cnt; go && instrOp == loe_pkg::LOE_OP_COUNTER && instrIndex == 8'h0
		|=> counterValue[15:0] <= $past(counterValue[15:0]) + 16'h1; endproperty
	property p_tmr; go && instrOp == loe_pkg::LOE_OP_TIMER && instrTarget == loe_pkg::LOE_TGT_TIMER
		&& instrIndex == 8'h0 && !opResult && timerMode[1:0] != 2'h2
		|=> timerValue[15:0] == 16'h0 && !timerContact[0]; endproperty
	a_coil: assert property (p_coil) else $error("coil differs from result");
	a_set: assert property (p_set) else $error("set relay not on");
	a_rst: assert property (p_rst) else $error("reset relay not off");
	a_stop: assert property (p_stop) else $error("relay changed while stopped");
	a_data: assert property (p_data) else $error("data clear missing");
	a_stepW: assert property (p_stepW) else $error("word reset steps wrong");
	a_stepR: assert property (p_stepR) else $error("relay steps wrong");
	a_cnt: assert property (p_cnt) else $error("counter stepped by more than one");
	a_tmr: assert property (p_tmr) else $error("timer not cleared on input off");
	c_set: cover property (rly && instrOp == loe_pkg::LOE_OP_SET && opResult);
	c_rise: cover property (go && instrOp == loe_pkg::LOE_OP_RISE);
	c_tmr: cover property (go && instrOp == loe_pkg::LOE_OP_TIMER && opResult);
endmodule // loe_executor_asserts
bind loe_ladder_output_executor loe_executor_asserts #(.NRELAY(NRELAY), .NTIMER(NTIMER), .NCOUNT(NCOUNT), .NDATA(NDATA))
	loe_executor_asserts_i (.clock(clock), .rst_n(rst_n), .run(run), .instrValid(instrValid), .instrOp(instrOp),
	.instrTarget(instrTarget), .instrIndex(instrIndex), .opResult(opResult), .instrSteps(instrSteps),
	.relayState(relayState), .timerContact(timerContact), .dataClearMask(dataClearMask), .timerValue(timerValue),
	.counterValue(counterValue), .timerMode(timerMode));

// ===== test/loe_ladder_output_executor_tb.sv
// Self-checking bench of the ladder output executor
`timescale 1ns/100ps
module loe_ladder_output_executor_tb;
	logic clock = 1'h0;
	logic rst_n = 1'h0;
	logic run = 1'h1;
	logic instrValid = 1'h0;
	logic opResult = 1'h0;
	loe_pkg::loe_op_e instrOp = loe_pkg::LOE_OP_NONE;
	loe_pkg::loe_tgt_e instrTarget = loe_pkg::LOE_TGT_RELAY;
	logic [7:0] instrIndex = 8'h0;
	logic [15:0] instrSetting = 16'h0;
	logic [7:0] instrPulseSlot = 8'h0;
	logic [2:0] instrSteps, steps;
	logic [63:0] relayState;
	logic [15:0] timerContact, counterContact;
	logic [15:0] timerCoil, counterCoil;
	// Timer 0 plain 100 ms, timer 1 retentive, timer 2 plain 10 ms
	logic [31:0] timerMode = 32'h18;
	logic [255:0] dataClearMask, timerValue, counterValue;
	int errCount = 0;
	int checks = 0;
	always #12.5 clock = ~clock;
	// Short bases keep the timer runs brief
	loe_ladder_output_executor #(.BASE100_CYC(20), .BASE10_CYC(2)) loe_ladder_output_executor_i (.clock(clock),
		.rst_n(rst_n), .run(run), .instrValid(instrValid), .instrOp(instrOp), .instrTarget(instrTarget),
		.instrIndex(instrIndex), .instrSetting(instrSetting), .instrPulseSlot(instrPulseSlot), .opResult(opResult),
		.instrSteps(instrSteps), .relayState(relayState), .timerCoil(timerCoil), .timerContact(timerContact),
		.counterCoil(counterCoil), .counterContact(counterContact), .dataClearMask(dataClearMask),
		.timerValue(timerValue), .counterValue(counterValue), .timerMode(timerMode));
	// ---------
	// Scenarios
	// ---------
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		checks++;
		if (s !== e) begin
			errCount++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic ex(input int o, input int t, input int i, input logic r, input int s = 0, input int p = 0);
		@(posedge clock);
		instrValid <= 1'h1;
		instrOp <= loe_pkg::loe_op_e'(o);
		instrTarget <= loe_pkg::loe_tgt_e'(t);
		instrIndex <= 8'(i);
		opResult <= r;
		instrSetting <= 16'(s);
		instrPulseSlot <= 8'(p);
		@(negedge clock);
		steps = instrSteps;
		@(posedge clock);
		instrValid <= 1'h0;
		@(negedge clock);
	endtask
	task automatic tCoilSet;
		ex(1, 0, 3, 1); chk("coil", relayState[3], 16'h1);
		chk("steps", steps, 16'h1);
		ex(1, 0, 3, 0); chk("coil", relayState[3], 16'h0);
		ex(1, 1, 4, 1); chk("steps", steps, 16'h3);
		ex(4, 0, 8, 1); ex(4, 0, 8, 0); chk("set", relayState[8], 16'h1);
		ex(5, 0, 8, 0); chk("rst off", relayState[8], 16'h1);
		ex(5, 0, 8, 1); chk("rst", relayState[8], 16'h0);
		ex(5, 4, 2, 1); chk("data", dataClearMask[47:32], 16'hffff);
		chk("steps", steps, 16'h3);
	endtask
	task automatic tCount;
		ex(3, 3, 1, 0); ex(3, 3, 1, 1); chk("cnt1", counterValue[31:16], 16'h1);
		chk("cnt1 ct", counterContact[1], 16'h1);
		chk("cnt1 coil", counterCoil[1], 16'h1);
		ex(3, 3, 0, 1, 3); ex(3, 3, 0, 1, 3); chk("cnt0", counterValue[15:0], 16'h1);
		repeat (2) begin ex(3, 3, 0, 0, 3); ex(3, 3, 0, 1, 3); end
		chk("cnt0", counterValue[15:0], 16'h3);
		chk("cnt0 ct", counterContact[0], 16'h1);
		ex(3, 3, 0, 0, 3); ex(3, 3, 0, 1, 3); chk("cnt0", counterValue[15:0], 16'h3);
		ex(5, 3, 0, 1); chk("cnt0", counterValue[15:0], 16'h0);
		chk("cnt0 ct", counterContact[0], 16'h0);
	endtask
	task automatic tTimer;
		// Settings stay nonnegative throughout
		ex(2, 2, 0, 1, 2); chk("tm0 ct", timerContact[0], 16'h0);
		repeat (15) begin ex(2, 2, 0, 1, 2); ex(2, 2, 1, 1, 2); ex(2, 2, 2, 1, 0); end
		chk("tm0", timerValue[15:0], 16'h2);
		chk("tm0 ct", timerContact[0], 16'h1);
		chk("tm0 coil", timerCoil[0], 16'h1);
		chk("tm2 ct", timerContact[2], 16'h0);
		chk("tm2 run", timerValue[47:32] != 16'h0, 16'h1);
		ex(2, 2, 0, 0, 2); chk("tm0", timerValue[15:0], 16'h0);
		chk("tm0 coil", timerCoil[0], 16'h0);
		ex(2, 2, 1, 0, 2); chk("tm1", timerValue[31:16], 16'h2);
		chk("tm1 ct", timerContact[1], 16'h1);
		ex(5, 2, 1, 1); chk("tm1 ct", timerContact[1], 16'h0);
	endtask
	task automatic tPulse;
		ex(6, 0, 5, 0); ex(6, 0, 5, 1); chk("rise", relayState[5], 16'h1);
		ex(6, 0, 5, 1); chk("rise", relayState[5], 16'h0);
		ex(7, 0, 6, 1, 0, 1); ex(7, 0, 6, 0, 0, 1); chk("fall", relayState[6], 16'h1);
		ex(7, 0, 6, 0, 0, 1); chk("fall", relayState[6], 16'h0);
		// A rise refused while stopped leaves its pulse slot as it was, so the restart gives no rise
		@(posedge clock) run <= 1'h0;
		ex(6, 0, 5, 0);
		@(posedge clock) run <= 1'h1;
		ex(6, 0, 5, 1); chk("restart", relayState[5], 16'h0);
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks, errCount);
		if (errCount == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge clock);
		rst_n <= 1'h1;
		tCoilSet();
		tCount();
		tTimer();
		tPulse();
		end_sim();
	end
	// Whole run is well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clock);
		errCount++;
		end_sim();
	end
endmodule // loe_ladder_output_executor_tb
